/* fpr_pkg.sv */
/*
 front panel reset and indicator block: shared constants and types.
 assumes a single 100 MHz board clock and a synchronous active-low reset.
*/
// ==========================================================================
// package
// ==========================================================================
package fpr_pkg;
   // board clock period in picoseconds
   localparam int unsigned CLK_PERIOD_PS = 10000;
   // debounce window in microseconds
   localparam int unsigned DEBOUNCE_US = 5000;
   // debounce window in clock cycles, rounded down; scaled in two steps
   // because the plain product would overflow 32 bits
   localparam int unsigned DEBOUNCE_CYC = (DEBOUNCE_US * 1000) / (CLK_PERIOD_PS / 1000);
   // counter width for the debounce window
   localparam int unsigned DEB_W = 20;
   // momentary system reset pulse in microseconds
   localparam int unsigned SYS_RESET_US = 200;
   // system reset pulse in clock cycles, rounded up
   localparam int unsigned SYS_RESET_CYC =
      (SYS_RESET_US * 1000000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   // counter width for the reset pulse
   localparam int unsigned RST_W = 16;
   // factory position of both rotary switches
   localparam logic [3:0] ROTARY_DEFAULT = 4'hf;
   // number of software user indicators
   localparam int unsigned USER_LEDS = 4;
   // port a field positions of the mode switch
   localparam int unsigned PORT_A_BIT_LSB = 0;
   localparam int unsigned PORT_A_BIT_MSB = 3;
   // decoded toggle position
   typedef enum logic [1:0]
   {
      FPR_POS_IDLE,
      FPR_POS_MOMENT,
      FPR_POS_HELD
   } fpr_pos_e;
endpackage

/* fpr_toggle_if.sv */
/*
 carrier between the top block and its toggle debouncer.
 assumes both ends run on the board clock.
*/
// ==========================================================================
// interface
// ==========================================================================
interface fpr_toggle_if;
   import fpr_pkg::*;
   logic     up_raw;   // synchronised upper contact
   logic     down_raw; // synchronised lower contact
   fpr_pos_e pos;      // debounced position
   logic     moment;   // one-cycle pulse on entering the upper position
   modport src (output up_raw, output down_raw, input pos, input moment);
   modport deb (input up_raw, input down_raw, output pos, output moment);
endinterface

/* fpr_debounce.sv */
/*
 debouncer for a three-position toggle switch.
 assumes its contact inputs are already synchronised to the board clock.
*/
module fpr_debounce
   import fpr_pkg::*;
#(
   parameter int unsigned DEB_CYCLES = DEBOUNCE_CYC
)
(
   input wire logic    i_mclk,
   input wire logic    i_rst_n,
   fpr_toggle_if.deb   tog
);
   // ======================================================================
   // position decode
   // ======================================================================
   fpr_pos_e            raw_pos;  // undebounced position
   fpr_pos_e            cand;     // candidate under test
   logic [DEB_W-1:0]    cnt;      // stability counter
   fpr_pos_e            pos;      // accepted position
   logic                moment;   // entry pulse

   // both contacts closed is impossible; treat as idle to be safe
   always_comb
   begin
      if (tog.up_raw && !tog.down_raw)
         raw_pos = FPR_POS_MOMENT;
      else if (tog.down_raw && !tog.up_raw)
         raw_pos = FPR_POS_HELD;
      else
         raw_pos = FPR_POS_IDLE;
   end

   // a position is accepted only after it stays put for the full window
   always_ff @(posedge i_mclk)
   begin
      if (!i_rst_n)
      begin
         cand   <= FPR_POS_IDLE;
         cnt    <= '0;
         pos    <= FPR_POS_IDLE;
         moment <= 1'b0;
      end
      else
      begin
         moment <= 1'b0;
         if (raw_pos != cand)
         begin
            cand <= raw_pos;
            cnt  <= '0;
         end
         else if (cnt < DEB_W'(DEB_CYCLES - 1))
            cnt <= cnt + 1'b1;
         else if (pos != cand)
         begin
            pos    <= cand;
            moment <= (cand == FPR_POS_MOMENT);
         end
      end
   end

   assign tog.pos    = pos;
   assign tog.moment = moment;
endmodule

/* fpr_front_panel.sv */
/*
 front panel switches and indicators of a backplane processor board.
 assumes panel contacts, backplane lines and processor lines arrive
 asynchronously; the io unit port pins are modelled as plain outputs.
*/
module fpr_front_panel
   import fpr_pkg::*;
#(
   parameter int unsigned DEB_CYCLES   = DEBOUNCE_CYC,
   parameter int unsigned RESET_CYCLES = SYS_RESET_CYC
)
(
   input  wire logic                 i_mclk,
   input  wire logic                 i_rst_n,
   input  wire logic                 i_reset_up,          // reset toggle upper contact
   input  wire logic                 i_reset_down,        // reset toggle lower contact
   input  wire logic                 i_abort_up,          // abort toggle upper contact
   input  wire logic                 i_abort_down,        // abort toggle lower contact
   input  wire logic                 i_backplane_reset_drive_enable, // slide switch
   input  wire logic [3:0]           i_mode_switch,       // mode rotary, true-coded
   input  wire logic [3:0]           i_second_hex_rotary_switch,
   input  wire logic [2:0]           i_nmi_level,         // programmed abort level
   input  wire logic                 i_cpu_reset_n,       // processor reset line
   input  wire logic                 i_cpu_halt_n,        // processor halt line
   input  wire logic                 i_cpu_bus_access,    // processor backplane cycle
   input  wire logic                 i_bus_shared_access, // backplane hits shared ram
   input  wire logic                 i_foreign_access,    // any foreign ram master
   input  wire logic                 i_bus_master,        // board owns the backplane
   input  wire logic                 i_fail_req,          // board wants fail asserted
   input  wire logic [USER_LEDS-1:0] i_user_pin,          // io unit led port values
   input  wire logic [USER_LEDS-1:0] i_user_pin_cfg,      // port pin configured
   output logic                      o_sys_reset_n,       // processor, array, devices
   output logic                      o_bp_reset_drive,    // backplane reset drive
   output logic                      o_bp_reset_oe,       // enable of reset driver
   output logic                      o_bp_fail_oe,        // enable of fail driver
   output logic                      o_bus_refuse,        // refuse backplane accesses
   output logic                      o_slot1_run,         // system clock/arbiter enable
   output logic                      o_cpu_halt_oe,       // drive processor halt low
   output logic                      o_nmi_req,           // abort interrupt request
   output logic [2:0]                o_nmi_level,         // level of that request
   output logic [3:0]                o_port_a_mode,       // port a mode switch data
   output logic [3:0]                o_port_a_second,     // port a second switch data
   output logic                      o_abort_switch_port_bit,
   output logic                      o_led_halt,
   output logic                      o_led_run,
   output logic                      o_led_foreign,
   output logic                      o_led_master,
   output logic [USER_LEDS-1:0]      o_led_user
);
   // ======================================================================
   // input synchronisers
   // ======================================================================
   localparam int unsigned NSYNC = 12; // asynchronous levels in the bundle
   logic [NSYNC-1:0] meta;    // first stage, read by second stage only
   logic [NSYNC-1:0] synced;  // second stage
   logic [NSYNC-1:0] raw_in;  // gathered asynchronous inputs

   // the bit order of this bundle fixes every index used below;
   // keep both in step when a line is added
   assign raw_in = {i_reset_up, i_reset_down, i_abort_up, i_abort_down,
                    i_backplane_reset_drive_enable, i_cpu_reset_n, i_cpu_halt_n,
                    i_cpu_bus_access, i_bus_shared_access, i_foreign_access,
                    i_bus_master, i_fail_req};

   // two flops on every level from outside the clock domain
   always_ff @(posedge i_mclk)
   begin
      if (!i_rst_n)
      begin
         meta   <= '0;
         synced <= '0;
      end
      else
      begin
         meta   <= raw_in;
         synced <= meta;
      end
   end

   logic s_rst_en, s_cpu_rst_n, s_cpu_halt_n, s_cpu_acc, s_shared;
   logic s_foreign, s_master, s_fail;
   // named views of the synchronised levels
   assign s_rst_en     = synced[7];
   assign s_cpu_rst_n  = synced[6];
   assign s_cpu_halt_n = synced[5];
   assign s_cpu_acc    = synced[4];
   assign s_shared     = synced[3];
   assign s_foreign    = synced[2];
   assign s_master     = synced[1];
   assign s_fail       = synced[0];

   // rotary switches are static straps; two flops each as well
   logic [3:0] mode_meta, mode_sync, sec_meta, sec_sync;

   always_ff @(posedge i_mclk)
   begin
      if (!i_rst_n)
      begin
         mode_meta <= ROTARY_DEFAULT;
         mode_sync <= ROTARY_DEFAULT;
         sec_meta  <= ROTARY_DEFAULT;
         sec_sync  <= ROTARY_DEFAULT;
      end
      else
      begin
         mode_meta <= i_mode_switch;
         mode_sync <= mode_meta;
         sec_meta  <= i_second_hex_rotary_switch;
         sec_sync  <= sec_meta;
      end
   end

   // ======================================================================
   // toggle debouncers
   // ======================================================================
   fpr_toggle_if rst_tog ();
   fpr_toggle_if abt_tog ();

   // contacts reach the debouncers already synchronised
   assign rst_tog.up_raw   = synced[11];
   assign rst_tog.down_raw = synced[10];
   assign abt_tog.up_raw   = synced[9];
   assign abt_tog.down_raw = synced[8];

   fpr_debounce #(.DEB_CYCLES (DEB_CYCLES)) u_rst_deb
   (
      .i_mclk  (i_mclk),
      .i_rst_n (i_rst_n),
      .tog     (rst_tog)
   );

   fpr_debounce #(.DEB_CYCLES (DEB_CYCLES)) u_abt_deb
   (
      .i_mclk  (i_mclk),
      .i_rst_n (i_rst_n),
      .tog     (abt_tog)
   );

   // ======================================================================
   // reset generation
   // ======================================================================
   logic [RST_W-1:0] pulse_cnt; // remaining cycles of system reset
   logic             held;      // debounced local-reset position

   assign held = (rst_tog.pos == FPR_POS_HELD);

   // a fixed-length pulse: a bouncing release cannot shorten the reset
   always_ff @(posedge i_mclk)
   begin
      if (!i_rst_n)
         pulse_cnt <= '0;
      else if (rst_tog.moment)
         pulse_cnt <= RST_W'(RESET_CYCLES);
      else if (pulse_cnt != '0)
         pulse_cnt <= pulse_cnt - 1'b1;
   end

   // the entry pulse loads the counter, the driver register follows one
   // cycle later, so the board reset shows two cycles after the pulse
   chk_moment_resets: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
      rst_tog.moment |=> ##1 !o_sys_reset_n)
      else $error("momentary reset missing");

   // board reset and backplane drivers
   always_ff @(posedge i_mclk)
   begin
      if (!i_rst_n)
      begin
         o_sys_reset_n    <= 1'b0;
         o_bp_reset_drive <= 1'b0;
         o_bp_reset_oe    <= 1'b0;
         o_bp_fail_oe     <= 1'b0;
         o_bus_refuse     <= 1'b1;
      end
      else
      begin
         o_sys_reset_n    <= !((pulse_cnt != '0) || held);
         o_bp_reset_drive <= 1'b0;
         // backplane reset only for the momentary pulse, never when held
         o_bp_reset_oe    <= (pulse_cnt != '0) && s_rst_en && !held;
         o_bp_fail_oe     <= s_fail && !held;
         o_bus_refuse     <= held;
      end
   end

   // held position keeps the board in reset and off the backplane
   chk_held_refuses_bus: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
      held |=> (o_bus_refuse && !o_sys_reset_n))
      else $error("held reset not applied");

   // neither backplane driver may pull its line while held
   chk_held_no_backplane: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
      held |=> (!o_bp_reset_oe && !o_bp_fail_oe))
      else $error("backplane driven while held");

   // backplane reset drive needs the enable switch a cycle earlier
   chk_bp_reset_enable: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
      o_bp_reset_oe |-> $past(s_rst_en))
      else $error("backplane reset without enable");

   // slot-one functions are deliberately not gated by any local reset
   always_ff @(posedge i_mclk)
   begin
      if (!i_rst_n)
         o_slot1_run <= 1'b0;
      else
         o_slot1_run <= 1'b1;
   end

   // slot-one functions must not pause while the board is held locally;
   // only the power-up reset may stop them
   chk_slot1_held: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
      held |=> o_slot1_run)
      else $error("slot one stopped while held");

   // ======================================================================
   // abort interrupt
   // ======================================================================
   // held-down abort is only status: the request follows the upper contact
   always_ff @(posedge i_mclk)
   begin
      if (!i_rst_n)
      begin
         o_nmi_req   <= 1'b0;
         o_nmi_level <= 3'h0;
      end
      else
      begin
         o_nmi_req   <= (abt_tog.pos == FPR_POS_MOMENT);
         o_nmi_level <= i_nmi_level;
      end
   end

   // an accepted upper position must raise the request next cycle;
   // a level request lets software see it for as long as the lever stays up
   chk_nmi_on_up: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
      (abt_tog.pos == FPR_POS_MOMENT) |=> o_nmi_req)
      else $error("abort request missing");

   // ======================================================================
   // halt logic and status lamps
   // ======================================================================
   logic halt_state; // processor reset or halt seen low

   assign halt_state = !s_cpu_rst_n || !s_cpu_halt_n;

   // retry request when a processor cycle meets an inbound shared access
   always_ff @(posedge i_mclk)
   begin
      if (!i_rst_n)
         o_cpu_halt_oe <= 1'b0;
      else
         o_cpu_halt_oe <= s_cpu_acc && s_shared;
   end

   // a collision must pull halt so the processor gives up and retries;
   // the lamp may flicker while this happens
   chk_retry_halt: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
      (s_cpu_acc && s_shared) |=> o_cpu_halt_oe)
      else $error("halt not asserted on collision");

   // status lamps
   always_ff @(posedge i_mclk)
   begin
      if (!i_rst_n)
      begin
         o_led_halt    <= 1'b1;
         o_led_run     <= 1'b0;
         o_led_foreign <= 1'b0;
         o_led_master  <= 1'b0;
      end
      else
      begin
         o_led_halt    <= halt_state;
         o_led_run     <= !halt_state;
         o_led_foreign <= s_foreign;
         o_led_master  <= s_master;
      end
   end

   // run and halt lamps are never lit or dark together
   chk_run_halt_inverse: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
      (o_led_run != o_led_halt))
      else $error("run lamp not inverse of halt");

   // halt lamp lights for a low reset or halt line
   chk_halt_lamp: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
      halt_state |=> o_led_halt)
      else $error("halt lamp off while halted");

   // and goes dark once both lines are high again
   chk_halt_lamp_off: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
      !halt_state |=> !o_led_halt)
      else $error("halt lamp lit while running");

   // ======================================================================
   // io unit ports
   // ======================================================================
   // an unconfigured pin floats high, which lights its lamp
   always_ff @(posedge i_mclk)
   begin
      if (!i_rst_n)
         o_led_user <= '1;
      else
         o_led_user <= i_user_pin | ~i_user_pin_cfg;
   end

   // a configured pin driven low must darken its lamp; only the first
   // lamp is watched, the others share the same gate
   chk_user_lamp: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
      (i_user_pin_cfg[0] && !i_user_pin[0]) |=> !o_led_user[0])
      else $error("user lamp lit on low pin");

   // readable switch data
   always_ff @(posedge i_mclk)
   begin
      if (!i_rst_n)
      begin
         o_port_a_mode           <= ROTARY_DEFAULT;
         o_port_a_second         <= ROTARY_DEFAULT;
         o_abort_switch_port_bit <= 1'b1;
      end
      else
      begin
         o_port_a_mode[PORT_A_BIT_MSB:PORT_A_BIT_LSB] <= mode_sync;
         o_port_a_second         <= sec_sync;
         o_abort_switch_port_bit <= !(abt_tog.pos == FPR_POS_HELD);
      end
   end

   // a held abort lever only shows on the port bit and never interrupts,
   // so a board left with the lever down still comes up quietly
   chk_abort_held_quiet: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
      (abt_tog.pos == FPR_POS_HELD) |=> (!o_nmi_req && !o_abort_switch_port_bit))
      else $error("held abort acted or not shown");

endmodule

/* fpr_toggle_model.sv */
/*
 model of one three-position front panel toggle with contact bounce.
 assumes the bench sets the position; contacts change on the falling edge.
*/
// ==========================================================================
// toggle model
// ==========================================================================
module fpr_toggle_model
   import fpr_pkg::*;
(
   input  wire logic     i_mclk,
   input  fpr_pos_e      i_pos,   // commanded lever position
   output logic          o_up,    // upper contact, high = closed
   output logic          o_down   // lower contact, high = closed
);
   fpr_pos_e   prev = FPR_POS_IDLE; // position seen at the last falling edge
   logic [1:0] age  = 2'h3;         // falling edges since the last change

   // age the lever position; a fresh change restarts the bounce
   always @(negedge i_mclk)
   begin
      prev <= i_pos;
      if (i_pos != prev)
      begin
         age <= 2'h0;
      end
      else if (age != 2'h3)
      begin
         age <= age + 2'h1;
      end
   end

   // middle closes nothing; one open cycle after a change mimics bounce,
   // so the debouncer never sees a clean edge into either end position
   assign o_up   = (prev == FPR_POS_MOMENT) && (age != 2'h1);
   assign o_down = (prev == FPR_POS_HELD) && (age != 2'h1);
endmodule

/* fpr_front_panel_tb_top.sv */
/*
 self-checking bench for the front panel block.
 assumes short debounce and reset counts; processor lines are wired here.
*/
// ==========================================================================
// bench top
// ==========================================================================
module fpr_front_panel_tb_top
   import fpr_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int unsigned DEB = 4; // shortened debounce window
   localparam int unsigned RST = 8; // shortened reset pulse
   logic       mclk = 1'b0;
   logic       rst_n = 1'b0;
   fpr_pos_e   reset_pos = FPR_POS_IDLE;
   fpr_pos_e   abort_pos = FPR_POS_IDLE;
   logic       r_up, r_dn, a_up, a_dn;
   logic       bp_en = 1'b0, ext_reset_n = 1'b1, ext_halt_n = 1'b1;
   logic       cpu_bus = 1'b0, shared = 1'b0, foreign = 1'b0, master = 1'b0;
   logic       fail_req = 1'b0;
   logic [3:0] mode = 4'hf, second = 4'hf, user_pin = 4'h0, user_cfg = 4'h0;
   logic [2:0] nmi_lvl = 3'h0;
   logic       sys_reset_n, bp_drive, bp_reset_oe, bp_fail_oe, bus_refuse, slot1_run;
   logic       halt_oe, nmi_req, abort_bit, led_halt, led_run, led_foreign, led_master;
   logic [2:0] nmi_level;
   logic [3:0] port_mode, port_second, led_user;
   logic       cpu_reset_n, cpu_halt_n;
   int         failures = 0;
   int         checks_done = 0;
   int         cycles = 0;
   int         n;

   // processor reset follows the board reset; halt is a wired-low line
   assign cpu_reset_n = sys_reset_n & ext_reset_n;
   assign cpu_halt_n  = ~halt_oe & ext_halt_n;

   always #5 mclk = ~mclk;

   fpr_toggle_model u_reset_tog (.i_mclk(mclk), .i_pos(reset_pos), .o_up(r_up), .o_down(r_dn));
   fpr_toggle_model u_abort_tog (.i_mclk(mclk), .i_pos(abort_pos), .o_up(a_up), .o_down(a_dn));

   fpr_front_panel #(.DEB_CYCLES(DEB), .RESET_CYCLES(RST)) dut (
      .i_mclk(mclk), .i_rst_n(rst_n), .i_reset_up(r_up), .i_reset_down(r_dn),
      .i_abort_up(a_up), .i_abort_down(a_dn), .i_backplane_reset_drive_enable(bp_en),
      .i_mode_switch(mode), .i_second_hex_rotary_switch(second), .i_nmi_level(nmi_lvl),
      .i_cpu_reset_n(cpu_reset_n), .i_cpu_halt_n(cpu_halt_n), .i_cpu_bus_access(cpu_bus),
      .i_bus_shared_access(shared), .i_foreign_access(foreign), .i_bus_master(master),
      .i_fail_req(fail_req), .i_user_pin(user_pin), .i_user_pin_cfg(user_cfg),
      .o_sys_reset_n(sys_reset_n), .o_bp_reset_drive(bp_drive), .o_bp_reset_oe(bp_reset_oe),
      .o_bp_fail_oe(bp_fail_oe), .o_bus_refuse(bus_refuse), .o_slot1_run(slot1_run),
      .o_cpu_halt_oe(halt_oe), .o_nmi_req(nmi_req), .o_nmi_level(nmi_level),
      .o_port_a_mode(port_mode), .o_port_a_second(port_second),
      .o_abort_switch_port_bit(abort_bit), .o_led_halt(led_halt), .o_led_run(led_run),
      .o_led_foreign(led_foreign), .o_led_master(led_master), .o_led_user(led_user));

   // ========================================================================
   // helpers
   // ========================================================================
   // compare with case equality so an unknown never passes
   task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
      checks_done++;
      if (seen !== exp)
      begin
         failures++;
         $display("MISMATCH %s expected %h seen %h", name, exp, seen);
      end
   endtask

   task automatic cyc(input int k);
      repeat (k) @(negedge mclk);
   endtask

   // single verdict point for the whole run
   task automatic finish_test();
      if (failures == 0 && checks_done > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask

   // hang guard: the sequence needs well under 2000 cycles
   always @(posedge mclk)
   begin
      cycles++;
      if (cycles == 5000)
      begin
         failures++;
         finish_test();
      end
   end

   // ========================================================================
   // test sequence
   // ========================================================================
   initial
   begin
      cyc(12);
      rst_n = 1'b1;
      cyc(8);
      check("mode_default", port_mode, 8'h0f);
      check("second_default", port_second, 8'h0f);
      check("idle_reset", sys_reset_n, 8'h01);
      check("idle_refuse", bus_refuse, 8'h00);
      mode = 4'h1;
      second = 4'h3;
      cyc(6);
      check("mode_order", port_mode, 8'h01);
      check("second_value", port_second, 8'h03);
      // status lamps over every combination of their inputs
      for (int i = 0; i < 16; i++)
      begin
         {ext_reset_n, ext_halt_n, foreign, master} = i[3:0];
         cyc(6);
         check("led_halt", led_halt, {7'h0, ~(i[3] & i[2])});
         check("led_run", led_run, {7'h0, i[3] & i[2]});
         check("led_foreign", led_foreign, {7'h0, i[1]});
         check("led_master", led_master, {7'h0, i[0]});
      end
      // only coinciding accesses pull the processor halt line
      for (int i = 0; i < 4; i++)
      begin
         {cpu_bus, shared} = i[1:0];
         cyc(9);
         check("halt_oe", halt_oe, {7'h0, i[1] & i[0]});
         check("halt_lamp", led_halt, {7'h0, i[1] & i[0]});
      end
      {cpu_bus, shared} = 2'h0;
      // user lamps: dark only where a configured pin is low
      for (int i = 0; i < 16; i++)
      begin
         user_pin = i[3:0];
         user_cfg = i[3:0] ^ 4'h5;
         cyc(2);
         check("led_user", led_user, {4'h0, i[3:0] | ~(i[3:0] ^ 4'h5)});
      end
      // momentary reset with backplane drive off and on
      for (int en = 0; en < 2; en++)
      begin
         bp_en = en[0];
         reset_pos = FPR_POS_MOMENT;
         n = 0;
         while (sys_reset_n !== 1'b0 && n < 40)
         begin
            n++;
            cyc(1);
         end
         check("bp_reset_oe", bp_reset_oe, {7'h0, en[0]});
         check("bp_drive", bp_drive, 8'h00);
         reset_pos = FPR_POS_IDLE;
         n = 0;
         while (sys_reset_n === 1'b0 && n < 40)
         begin
            n++;
            cyc(1);
         end
         check("pulse_len", 8'(n), 8'(RST));
         check("bp_reset_end", bp_reset_oe, 8'h00);
         cyc(20);
      end
      // held local reset masks fail and reset drive, slot one keeps going
      fail_req = 1'b1;
      cyc(6);
      check("fail_normal", bp_fail_oe, 8'h01);
      reset_pos = FPR_POS_HELD;
      cyc(20);
      check("held_reset", sys_reset_n, 8'h00);
      check("held_refuse", bus_refuse, 8'h01);
      check("held_fail", bp_fail_oe, 8'h00);
      check("held_bp_reset", bp_reset_oe, 8'h00);
      check("held_slot1", slot1_run, 8'h01);
      reset_pos = FPR_POS_IDLE;
      fail_req = 1'b0;
      cyc(20);
      check("release_reset", sys_reset_n, 8'h01);
      check("release_refuse", bus_refuse, 8'h00);
      // a bouncy touch shorter than the window must be ignored
      reset_pos = FPR_POS_MOMENT;
      cyc(2);
      reset_pos = FPR_POS_IDLE;
      n = 0;
      repeat (20)
      begin
         cyc(1);
         n += (sys_reset_n !== 1'b1);
      end
      check("glitch_ignored", 8'(n), 8'h00);
      // abort toggle: up requests the interrupt, down only reads low
      nmi_lvl = 3'h5;
      abort_pos = FPR_POS_MOMENT;
      cyc(12);
      check("nmi_up", nmi_req, 8'h01);
      check("nmi_level", nmi_level, 8'h05);
      check("abort_bit_up", abort_bit, 8'h01);
      abort_pos = FPR_POS_HELD;
      cyc(12);
      check("nmi_down", nmi_req, 8'h00);
      check("abort_bit_down", abort_bit, 8'h00);
      abort_pos = FPR_POS_IDLE;
      cyc(12);
      check("abort_bit_idle", abort_bit, 8'h01);
      for (int l = 0; l < 8; l++)
      begin
         nmi_lvl = l[2:0];
         cyc(2);
         check("nmi_level_prog", nmi_level, {5'h0, l[2:0]});
      end
      // a second reset in mid-run brings back the reset values
      rst_n = 1'b0;
      cyc(3);
      check("rst_sys_reset", sys_reset_n, 8'h00);
      check("rst_mode", port_mode, 8'h0f);
      check("rst_second", port_second, 8'h0f);
      check("rst_user", led_user, 8'h0f);
      check("rst_run", led_run, 8'h00);
      rst_n = 1'b1;
      cyc(8);
      check("rst_release", sys_reset_n, 8'h01);
      check("rst_mode_back", port_mode, 8'h01);
      finish_test();
   end
endmodule
